// ==== hdl/reply_pkg.sv ====
// Purpose: Shared constants for the turnaround reply framer
// Assumes: One core clock, synchronous active-high reset
// Notes: Offsets are byte addresses on the register bus
package reply_pkg;
   // Reply data types, six bits
   localparam logic [5:0] DT_ACK_ERR = 6'h02;
   localparam logic [5:0] DT_ACK = 6'h19;
   localparam logic [5:0] DT_GEN_SHORT = 6'h10;
   localparam logic [5:0] DT_GEN_LONG = 6'h1A;
   localparam logic [5:0] DT_CMD_LONG = 6'h1C;
   localparam logic [5:0] DT_CMD_SHORT = 6'h20;
   // Error report bit positions
   localparam int BIT_SOT = 0;
   localparam int BIT_SOT_SYNC = 1;
   localparam int BIT_EOT_SYNC = 2;
   localparam int BIT_ESCAPE = 3;
   localparam int BIT_LP_SYNC = 4;
   localparam int BIT_RX_TIMEOUT = 5;
   localparam int BIT_ECC_ONE = 8;
   localparam int BIT_ECC_MULTI = 9;
   localparam int BIT_CHECKSUM = 10;
   localparam int BIT_TYPE = 11;
   localparam int BIT_CHANNEL = 12;
   localparam int ERR_W = 16;
   // Errors that forbid any read or write access
   localparam logic [15:0] ERR_ABORT_MASK = 16'h1A03;
   // Check bytes sent when no code is computed
   localparam logic [7:0] ECC_NONE = 8'h00;
   localparam logic [7:0] CSUM_NONE = 8'h00;
   // Last byte index of each fixed segment
   localparam logic [15:0] ACK_LAST = 16'h0001;
   localparam logic [15:0] ERR_LAST = 16'h0003;
   localparam logic [15:0] LONG_HDR_LAST = 16'h0003;
   localparam logic [15:0] CSUM_LAST = 16'h0001;
   // Register map
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_COUNT = 8'h08;
   localparam int CTRL_EN_BIT = 0;
   localparam int STATUS_BUSY_BIT = 16;
   localparam logic CTRL_EN_RESET = 1'b1;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic HRESP_OKAY = 1'b0;
   typedef enum {
      S_IDLE, S_ACK, S_ERR, S_WAIT_HDR, S_RD_HEAD, S_RD_REQ,
      S_RD_WAIT, S_RD_PUT, S_RD_TAIL, S_DRAIN
   } state_e;
endpackage

// ==== hdl/error_collector.sv ====
// Purpose: Gathers error events of one host transmission
// Assumes: Error inputs are one-cycle events on the core clock
// Notes: Events in the clearing cycle are delivered through err_now
`timescale 1ns/1ns
`default_nettype none
module error_collector
   import reply_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Error events
   input wire logic e_sot,
   input wire logic e_sot_sync,
   input wire logic e_eot_sync,
   input wire logic e_escape,
   input wire logic e_lp_sync,
   input wire logic e_rx_timeout,
   input wire logic e_ecc_one,
   input wire logic e_ecc_multi,
   input wire logic e_checksum,
   input wire logic e_type,
   input wire logic e_channel,
   // Consume the gathered field
   input wire logic clr,
   output logic [15:0] err_now
);
   logic [15:0] raw;
   logic [15:0] sticky;

   always_comb begin
      raw = '0;
      raw[BIT_SOT] = e_sot;
      raw[BIT_SOT_SYNC] = e_sot_sync;
      raw[BIT_EOT_SYNC] = e_eot_sync;
      raw[BIT_ESCAPE] = e_escape;
      raw[BIT_LP_SYNC] = e_lp_sync;
      raw[BIT_RX_TIMEOUT] = e_rx_timeout;
      raw[BIT_ECC_ONE] = e_ecc_one;
      raw[BIT_ECC_MULTI] = e_ecc_multi;
      raw[BIT_CHECKSUM] = e_checksum;
      raw[BIT_TYPE] = e_type;
      raw[BIT_CHANNEL] = e_channel;
   end

   // Same-cycle events are not dropped: they go out in err_now
   assign err_now = sticky | raw;

   always_ff @(posedge clk) begin
      if (rst) begin
         sticky <= '0;
      end else if (clr) begin
         sticky <= '0;
      end else begin
         sticky <= err_now;
      end
   end

   chk_event_sticks: assert property (@(posedge clk) disable iff (rst)
      (!clr && e_checksum) |=> sticky[BIT_CHECKSUM])
      else $error("checksum event not held");
   chk_clear_empties: assert property (@(posedge clk) disable iff (rst)
      clr |=> (sticky == '0))
      else $error("field not emptied after consume");
endmodule
`default_nettype wire

// ==== hdl/reply_framer.sv ====
// Purpose: Frames the peripheral reply after bus turnaround
// Assumes: Host events arrive while idle; TX_READY accepts bytes
// Notes: ECC and checksum are not computed, zeros are sent instead
//
// The AHB-Lite register port and the address map were decided locally.
`timescale 1ns/1ns
`default_nettype none
module reply_framer
   import reply_pkg::*;
(
   // Clock and reset
   input wire logic CORE_CLK,
   input wire logic RST,
   // Register bus
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   output logic HREADYOUT,
   output logic [31:0] HRDATA,
   output logic HRESP,
   // End of host transmission
   input wire logic EOT_STROBE,
   input wire logic EOT_TURN,
   input wire logic REQ_IS_READ,
   input wire logic [1:0] REQ_VC,
   // Receiver error events
   input wire logic ERR_SOT,
   input wire logic ERR_SOT_SYNC,
   input wire logic ERR_EOT_SYNC,
   input wire logic ERR_ESCAPE,
   input wire logic ERR_LP_SYNC,
   input wire logic ERR_RX_TIMEOUT,
   input wire logic ERR_ECC_ONE,
   input wire logic ERR_ECC_MULTI,
   input wire logic ERR_CHECKSUM,
   input wire logic ERR_TYPE,
   input wire logic ERR_CHANNEL,
   // Application side
   output logic CMD_EXEC,
   output logic READ_REQ,
   input wire logic RD_VALID,
   input wire logic RD_LONG,
   input wire logic RD_CMDSET,
   input wire logic [15:0] RD_LEN,
   output logic RD_BYTE_REQ,
   input wire logic RD_BYTE_VALID,
   input wire logic [7:0] RD_BYTE,
   // Reverse link bytes
   output logic [7:0] TX_BYTE,
   output logic TX_VALID,
   output logic TX_LAST,
   input wire logic TX_READY,
   output logic TURN_REQ
);
   state_e state;
   logic [15:0] err_now;
   logic [15:0] rep;
   logic [15:0] idx;
   logic [15:0] rd_len;
   logic [1:0] vc;
   logic rd_long;
   logic rd_cmdset;
   logic [7:0] hold;
   logic ctrl_en;
   logic [31:0] reply_count;
   logic take;
   logic abort;
   logic load_ok;
   logic emitting;
   logic seg_end;
   logic [7:0] out_byte;
   logic out_last;
   logic ap_valid;
   logic ap_write;
   logic [7:0] ap_addr;

   function automatic logic [7:0] ident(input logic [1:0] ch,
                                        input logic [5:0] dt);
      ident = {ch, dt};
   endfunction

   error_collector error_collector_inst (
      .clk(CORE_CLK),
      .rst(RST),
      .e_sot(ERR_SOT),
      .e_sot_sync(ERR_SOT_SYNC),
      .e_eot_sync(ERR_EOT_SYNC),
      .e_escape(ERR_ESCAPE),
      .e_lp_sync(ERR_LP_SYNC),
      .e_rx_timeout(ERR_RX_TIMEOUT),
      .e_ecc_one(ERR_ECC_ONE),
      .e_ecc_multi(ERR_ECC_MULTI),
      .e_checksum(ERR_CHECKSUM),
      .e_type(ERR_TYPE),
      .e_channel(ERR_CHANNEL),
      .clr(take),
      .err_now(err_now)
   );

   // Events while a reply is under way are not ours to judge
   assign take = EOT_STROBE && (state == S_IDLE) && ctrl_en;
   assign abort = (err_now & ERR_ABORT_MASK) != '0;
   assign load_ok = !TX_VALID || TX_READY;

   // Byte to place on the link for the present state
   always_comb begin
      emitting = 1'b0;
      seg_end = 1'b0;
      out_last = 1'b0;
      out_byte = ECC_NONE;
      case (state)
         S_ACK: begin
            emitting = 1'b1;
            out_byte = (idx == '0) ? ident(vc, DT_ACK) : ECC_NONE;
            seg_end = (idx == ACK_LAST);
            out_last = seg_end;
         end
         S_ERR: begin
            emitting = 1'b1;
            case (idx[1:0])
               2'h0: out_byte = ident(vc, DT_ACK_ERR);
               2'h1: out_byte = rep[7:0];
               2'h2: out_byte = rep[15:8];
               default: out_byte = ECC_NONE;
            endcase
            seg_end = (idx == ERR_LAST);
            out_last = seg_end;
         end
         S_RD_HEAD: begin
            emitting = 1'b1;
            if (rd_long) begin
               case (idx[1:0])
                  2'h0: out_byte =
                     ident(vc, rd_cmdset ? DT_CMD_LONG : DT_GEN_LONG);
                  2'h1: out_byte = rd_len[7:0];
                  2'h2: out_byte = rd_len[15:8];
                  default: out_byte = ECC_NONE;
               endcase
               seg_end = (idx == LONG_HDR_LAST);
            end else begin
               out_byte = ident(vc, (rd_cmdset ? DT_CMD_SHORT : DT_GEN_SHORT)
                  | {3'h0, rd_len[2:0]});
               seg_end = 1'b1;
            end
         end
         S_RD_PUT: begin
            emitting = 1'b1;
            out_byte = hold;
            seg_end = (idx == rd_len - 16'h0001);
         end
         S_RD_TAIL: begin
            emitting = 1'b1;
            out_byte = rd_long ? CSUM_NONE : ECC_NONE;
            seg_end = rd_long ? (idx == CSUM_LAST) : 1'b1;
            out_last = seg_end && (rep == '0);
         end
         default: begin
            emitting = 1'b0;
         end
      endcase
   end

   // Reply sequencing and link bytes
   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         state <= S_IDLE;
         idx <= '0;
         rep <= '0;
         vc <= '0;
         rd_long <= 1'b0;
         rd_cmdset <= 1'b0;
         rd_len <= '0;
         hold <= '0;
         TX_BYTE <= '0;
         TX_VALID <= 1'b0;
         TX_LAST <= 1'b0;
         CMD_EXEC <= 1'b0;
         READ_REQ <= 1'b0;
         RD_BYTE_REQ <= 1'b0;
         TURN_REQ <= 1'b0;
      end else begin
         CMD_EXEC <= 1'b0;
         READ_REQ <= 1'b0;
         RD_BYTE_REQ <= 1'b0;
         TURN_REQ <= 1'b0;
         if (TX_VALID && TX_READY) begin
            TX_VALID <= 1'b0;
         end
         if (emitting && load_ok) begin
            TX_BYTE <= out_byte;
            TX_VALID <= 1'b1;
            TX_LAST <= out_last;
            idx <= seg_end ? '0 : idx + 16'h0001;
         end
         case (state)
            S_IDLE: begin
               if (take) begin
                  rep <= err_now;
                  vc <= REQ_VC;
                  idx <= '0;
                  // Corrected headers still execute
                  CMD_EXEC <= !abort && !REQ_IS_READ;
                  if (EOT_TURN) begin
                     if (abort) begin
                        state <= S_ERR;
                     end else if (REQ_IS_READ) begin
                        READ_REQ <= 1'b1;
                        state <= S_WAIT_HDR;
                     end else if (err_now != '0) begin
                        state <= S_ERR;
                     end else begin
                        state <= S_ACK;
                     end
                  end
               end
            end
            S_WAIT_HDR: begin
               if (RD_VALID) begin
                  rd_long <= RD_LONG;
                  rd_cmdset <= RD_CMDSET;
                  rd_len <= RD_LONG ? RD_LEN : {13'h0000, RD_LEN[2:0]};
                  state <= S_RD_HEAD;
               end
            end
            S_RD_HEAD: begin
               if (load_ok && seg_end) begin
                  state <= (rd_len == '0) ? S_RD_TAIL : S_RD_REQ;
               end
            end
            S_RD_REQ: begin
               RD_BYTE_REQ <= 1'b1;
               state <= S_RD_WAIT;
            end
            S_RD_WAIT: begin
               if (RD_BYTE_VALID) begin
                  hold <= RD_BYTE;
                  state <= S_RD_PUT;
               end
            end
            S_RD_PUT: begin
               if (load_ok) begin
                  state <= seg_end ? S_RD_TAIL : S_RD_REQ;
               end
            end
            S_RD_TAIL: begin
               if (load_ok && seg_end) begin
                  // One report only, after the data
                  state <= (rep != '0) ? S_ERR : S_DRAIN;
               end
            end
            S_ACK, S_ERR: begin
               if (load_ok && seg_end) begin
                  state <= S_DRAIN;
               end
            end
            S_DRAIN: begin
               if (TX_VALID && TX_READY) begin
                  TURN_REQ <= 1'b1;
                  state <= S_IDLE;
               end
            end
            default: begin
               state <= S_IDLE;
            end
         endcase
      end
   end

   // Replies completed, for software
   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         reply_count <= '0;
      end else if (state == S_DRAIN && TX_VALID && TX_READY) begin
         reply_count <= reply_count + 32'h0000_0001;
      end
   end

   // Bus slave, zero wait states
   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         ap_valid <= 1'b0;
         ap_write <= 1'b0;
         ap_addr <= '0;
         HRDATA <= '0;
         HREADYOUT <= 1'b1;
         HRESP <= HRESP_OKAY;
      end else begin
         ap_valid <= HSEL && (HTRANS == HTRANS_NONSEQ) && HREADY;
         ap_write <= HWRITE;
         ap_addr <= HADDR[7:0];
         if (HSEL && (HTRANS == HTRANS_NONSEQ) && HREADY && !HWRITE) begin
            case (HADDR[7:0])
               REG_CTRL: HRDATA <= {31'h0000_0000, ctrl_en};
               REG_STATUS: HRDATA <= {15'h0000, state != S_IDLE, rep};
               REG_COUNT: HRDATA <= reply_count;
               default: HRDATA <= '0;
            endcase
         end
      end
   end

   // Disabling makes the block ignore host transmissions
   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         ctrl_en <= CTRL_EN_RESET;
      end else if (ap_valid && ap_write && ap_addr == REG_CTRL) begin
         ctrl_en <= HWDATA[CTRL_EN_BIT];
      end
   end

   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (RST);

   chk_no_turn_silent: assert property (
      (take && !EOT_TURN) |=> (state == S_IDLE) [*3] ##0 !TX_VALID)
      else $error("reply sent without turnaround");
   chk_plain_ack: assert property (
      (take && EOT_TURN && !REQ_IS_READ && err_now == '0)
      |=> state == S_ACK ##1 (TX_BYTE == {vc, DT_ACK} && TX_VALID))
      else $error("plain acknowledge not framed");
   chk_read_issue: assert property (
      (take && EOT_TURN && REQ_IS_READ && !abort) |=> READ_REQ && !CMD_EXEC)
      else $error("read not requested");
   chk_abort_access: assert property (
      (take && abort) |=> !CMD_EXEC && !READ_REQ)
      else $error("access despite fatal error");
   chk_multi_exec: assert property (
      (take && err_now[BIT_ECC_MULTI]) |=> !CMD_EXEC)
      else $error("command run with multi-bit error");
   chk_err_layout: assert property (
      (state == S_ERR && idx == '0 && load_ok)
      |=> TX_BYTE == {vc, DT_ACK_ERR} && TX_VALID)
      else $error("error report identifier wrong");
   chk_err_low: assert property (
      (state == S_ERR && idx == 16'h0001 && load_ok)
      |=> TX_BYTE == rep[7:0] && TX_VALID)
      else $error("error report low byte wrong");
   chk_ack_tail: assert property (
      (state == S_ACK && idx == ACK_LAST && load_ok)
      |=> TX_BYTE == ECC_NONE && TX_LAST)
      else $error("acknowledge tail wrong");
   chk_short_count: assert property (
      (state == S_RD_HEAD && !rd_long && load_ok)
      |=> TX_BYTE[2:0] == rd_len[2:0])
      else $error("short read count wrong");
   chk_report_follows: assert property (
      (state == S_RD_TAIL && seg_end && load_ok && rep != '0)
      |=> state == S_ERR && !TX_LAST)
      else $error("report missing after read data");
   chk_hand_back: assert property (
      (state == S_DRAIN && TX_VALID && TX_LAST && TX_READY)
      |=> TURN_REQ ##1 !TURN_REQ)
      else $error("bus not handed back");
   chk_single_report: assert property (
      (state == S_ERR && seg_end && load_ok) |=> state == S_DRAIN)
      else $error("second report in transmission");

   cov_ack: cover property (state == S_ACK ##[1:20] TURN_REQ);
   cov_read_report: cover property (state == S_RD_TAIL ##1 state == S_ERR);
   cov_abort: cover property (take && abort && EOT_TURN);
endmodule
`default_nettype wire

// ==== test/host_link_model.sv ====
// Purpose: Host-side link receiver for the reverse reply bytes
// Assumes: Bytes pass on edges where TX_VALID and TX_READY are high
// Notes: Slow mode drops ready every other cycle to stall the framer
`timescale 1ns/1ns
`default_nettype none
module host_link_model (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Reverse link
   input wire logic [7:0] tx_byte,
   input wire logic tx_valid,
   input wire logic tx_last,
   output logic tx_ready,
   input wire logic turn_req,
   // Pacing
   input wire logic slow
);
   logic [7:0] got[$];
   logic lasts[$];
   int turns;
   initial begin
      tx_ready = 1'b0;
      turns = 0;
   end
   always @(posedge clk) begin
      if (rst) begin
         tx_ready <= 1'b0;
      end else begin
         // Host takes every byte offered while ready
         if (tx_valid && tx_ready) begin
            got.push_back(tx_byte);
            lasts.push_back(tx_last);
         end
         // Bus handed back to the host
         if (turn_req) begin
            turns++;
         end
         tx_ready <= slow ? ~tx_ready : 1'b1;
      end
   end
endmodule
`default_nettype wire

// ==== test/reply_framer_tb_top.sv ====
// Purpose: Self-checking bench for the turnaround reply framer
// Assumes: ECC and checksum bytes are sent as zeros
// Notes: Read data bytes come from a counting pattern starting at C0
`timescale 1ns/1ns
`default_nettype none
module reply_framer_tb_top;
   import reply_pkg::*;
   localparam int AB[5] = '{0, 1, 9, 11, 12};
   localparam int NB[6] = '{2, 3, 4, 5, 8, 10};
   logic CORE_CLK, RST, HSEL, HWRITE, HREADYOUT, HRESP;
   logic [31:0] HADDR, HWDATA, HRDATA;
   logic [1:0] HTRANS, REQ_VC;
   logic [2:0] HSIZE;
   logic EOT_STROBE, EOT_TURN, REQ_IS_READ, CMD_EXEC, READ_REQ;
   logic RD_VALID, RD_LONG, RD_CMDSET, RD_BYTE_REQ, RD_BYTE_VALID;
   logic [15:0] RD_LEN, err_drive;
   logic [7:0] RD_BYTE, TX_BYTE, app_idx;
   logic TX_VALID, TX_LAST, TX_READY, TURN_REQ, slow;
   logic [3:0] app_wait;
   int errors, n_tests, n_exec, n_rdreq;
   logic [31:0] rv;

   reply_framer reply_framer_inst (.CORE_CLK(CORE_CLK), .RST(RST),
      .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE),
      .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADYOUT),
      .HREADYOUT(HREADYOUT), .HRDATA(HRDATA), .HRESP(HRESP),
      .EOT_STROBE(EOT_STROBE), .EOT_TURN(EOT_TURN),
      .REQ_IS_READ(REQ_IS_READ), .REQ_VC(REQ_VC),
      .ERR_SOT(err_drive[BIT_SOT]), .ERR_SOT_SYNC(err_drive[BIT_SOT_SYNC]),
      .ERR_EOT_SYNC(err_drive[BIT_EOT_SYNC]),
      .ERR_ESCAPE(err_drive[BIT_ESCAPE]), .ERR_LP_SYNC(err_drive[BIT_LP_SYNC]),
      .ERR_RX_TIMEOUT(err_drive[BIT_RX_TIMEOUT]),
      .ERR_ECC_ONE(err_drive[BIT_ECC_ONE]),
      .ERR_ECC_MULTI(err_drive[BIT_ECC_MULTI]),
      .ERR_CHECKSUM(err_drive[BIT_CHECKSUM]), .ERR_TYPE(err_drive[BIT_TYPE]),
      .ERR_CHANNEL(err_drive[BIT_CHANNEL]), .CMD_EXEC(CMD_EXEC),
      .READ_REQ(READ_REQ), .RD_VALID(RD_VALID), .RD_LONG(RD_LONG),
      .RD_CMDSET(RD_CMDSET), .RD_LEN(RD_LEN), .RD_BYTE_REQ(RD_BYTE_REQ),
      .RD_BYTE_VALID(RD_BYTE_VALID), .RD_BYTE(RD_BYTE), .TX_BYTE(TX_BYTE),
      .TX_VALID(TX_VALID), .TX_LAST(TX_LAST), .TX_READY(TX_READY),
      .TURN_REQ(TURN_REQ));
   host_link_model host_link_model_inst (.clk(CORE_CLK), .rst(RST),
      .tx_byte(TX_BYTE), .tx_valid(TX_VALID), .tx_last(TX_LAST),
      .tx_ready(TX_READY), .turn_req(TURN_REQ), .slow(slow));

   initial begin
      CORE_CLK = 1'b0;
      forever #5 CORE_CLK = ~CORE_CLK;
   end

   // Application side: header three cycles after the fetch, bytes on demand
   always @(posedge CORE_CLK) begin
      RD_VALID <= 1'b0;
      RD_BYTE_VALID <= 1'b0;
      if (CMD_EXEC) n_exec++;
      if (READ_REQ) begin
         n_rdreq++;
         app_wait <= 4'h3;
         app_idx <= 8'h00;
      end else if (app_wait != 4'h0) begin
         app_wait <= app_wait - 4'h1;
         RD_VALID <= (app_wait == 4'h1);
      end
      if (RD_BYTE_REQ) begin
         RD_BYTE_VALID <= 1'b1;
         RD_BYTE <= 8'hC0 + app_idx;
         app_idx <= app_idx + 8'h01;
      end
   end

   task automatic check_val(input string what, input logic [31:0] exp,
                            input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         errors++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic conclude;
      $display("Comparisons %0d, mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic ahb(input logic wr, input logic [7:0] a,
                      input logic [31:0] wd, output logic [31:0] rd);
      int k;
      HSEL <= 1'b1;
      HTRANS <= HTRANS_NONSEQ;
      HADDR <= {24'h000000, a};
      HWRITE <= wr;
      HSIZE <= 3'h2;
      k = 0;
      do begin @(posedge CORE_CLK); k++; end
      while (HREADYOUT !== 1'b1 && k < 50);
      HSEL <= 1'b0;
      HTRANS <= 2'h0;
      HWDATA <= wd;
      do begin @(posedge CORE_CLK); k++; end
      while (HREADYOUT !== 1'b1 && k < 50);
      if (k >= 50) errors++;
      rd = HRDATA;
      check_val("hresp", {31'h0, HRESP_OKAY}, {31'h0, HRESP});
   endtask

   // One host transmission, then judge the whole reply
   task automatic xfer(input logic en, turn, rd, input logic [1:0] vc,
      input logic [15:0] err, input logic lng, cs, input logic [15:0] len);
      logic [7:0] q[$];
      logic ab;
      int e0, r0, t0, k, n;
      ab = |(err & ERR_ABORT_MASK);
      n = lng ? int'(len) : int'(len[2:0]);
      if (en && turn) begin
         if (rd && !ab) begin
            if (lng) begin
               q.push_back({vc, cs ? DT_CMD_LONG : DT_GEN_LONG});
               q.push_back(len[7:0]);
               q.push_back(len[15:8]);
               q.push_back(ECC_NONE);
            end else begin
               q.push_back({vc, (cs ? DT_CMD_SHORT : DT_GEN_SHORT)
                  | {3'h0, len[2:0]}});
            end
            for (k = 0; k < n; k++) q.push_back(8'hC0 + k[7:0]);
            if (lng) begin
               q.push_back(CSUM_NONE);
               q.push_back(CSUM_NONE);
            end else q.push_back(ECC_NONE);
         end
         if (!rd && err == 16'h0000) begin
            q.push_back({vc, DT_ACK});
            q.push_back(ECC_NONE);
         end else if (err != 16'h0000) begin
            q.push_back({vc, DT_ACK_ERR});
            q.push_back(err[7:0]);
            q.push_back(err[15:8]);
            q.push_back(ECC_NONE);
         end
      end
      e0 = n_exec;
      r0 = n_rdreq;
      t0 = host_link_model_inst.turns;
      host_link_model_inst.got.delete();
      host_link_model_inst.lasts.delete();
      err_drive <= err;
      @(posedge CORE_CLK);
      err_drive <= 16'h0000;
      EOT_STROBE <= 1'b1;
      EOT_TURN <= turn;
      REQ_IS_READ <= rd;
      REQ_VC <= vc;
      RD_LONG <= lng;
      RD_CMDSET <= cs;
      RD_LEN <= len;
      @(posedge CORE_CLK);
      EOT_STROBE <= 1'b0;
      k = 0;
      while (q.size() != 0 && host_link_model_inst.turns == t0 && k < 2000)
      begin
         @(posedge CORE_CLK);
         k++;
      end
      if (k >= 2000) errors++;
      repeat (10) @(posedge CORE_CLK);
      check_val("exec", {31'h0, en && !rd && !ab}, n_exec - e0);
      check_val("fetch", {31'h0, en && turn && rd && !ab},
                n_rdreq - r0);
      check_val("turns", {31'h0, q.size() != 0},
                host_link_model_inst.turns - t0);
      check_val("count", q.size(), host_link_model_inst.got.size());
      for (k = 0; k < q.size() && k < host_link_model_inst.got.size(); k++)
      begin
         check_val("byte", q[k], host_link_model_inst.got[k]);
         check_val("last", k == q.size() - 1,
                   host_link_model_inst.lasts[k]);
      end
   endtask

   task automatic t_regs_reset;
      ahb(1'b0, REG_CTRL, 32'h0, rv);
      check_val("ctrl", {31'h0, CTRL_EN_RESET}, {31'h0, rv[CTRL_EN_BIT]});
      ahb(1'b0, REG_STATUS, 32'h0, rv);
      check_val("status", 32'h0, rv);
      ahb(1'b0, REG_COUNT, 32'h0, rv);
      check_val("replies", 32'h0, rv);
      ahb(1'b0, 8'h0C, 32'h0, rv);
      check_val("unmapped", 32'h0, rv);
   endtask

   task automatic t_ack;
      xfer(1, 1, 0, 2'h1, 16'h0, 0, 0, 16'h0);
      xfer(1, 1, 0, 2'h3, 16'h0, 0, 0, 16'h0);
      ahb(1'b0, REG_COUNT, 32'h0, rv);
      check_val("replies", 32'h2, rv);
   endtask

   task automatic t_no_turn;
      xfer(1, 0, 0, 2'h2, 16'h0, 0, 0, 16'h0);
      xfer(1, 0, 0, 2'h2, 16'h0400, 0, 0, 16'h0);
      xfer(1, 0, 1, 2'h1, 16'h0, 0, 0, 16'h3);
   endtask

   task automatic t_reads;
      slow <= 1'b1;
      xfer(1, 1, 1, 2'h2, 16'h0, 0, 0, 16'h3);
      xfer(1, 1, 1, 2'h1, 16'h0, 0, 1, 16'h7);
      xfer(1, 1, 1, 2'h0, 16'h0, 0, 0, 16'h0);
      xfer(1, 1, 1, 2'h3, 16'h0, 1, 0, 16'h5);
      slow <= 1'b0;
      xfer(1, 1, 1, 2'h1, 16'h0, 1, 1, 16'h2);
   endtask

   task automatic t_read_err;
      xfer(1, 1, 1, 2'h1, 16'h0500, 0, 0, 16'h4);
      xfer(1, 1, 1, 2'h2, 16'h0100, 1, 1, 16'h3);
   endtask

   task automatic t_abort;
      int i;
      for (i = 0; i < 5; i++) begin
         xfer(1, 1, 0, 2'h1, 16'h1 << AB[i], 0, 0, 16'h0);
         xfer(1, 1, 1, 2'h2, 16'h1 << AB[i], 0, 0, 16'h2);
      end
      xfer(1, 1, 1, 2'h3, 16'h1A03, 1, 0, 16'h2);
   endtask

   task automatic t_report;
      int i;
      for (i = 0; i < 6; i++) begin
         xfer(1, 1, 0, 2'h2, 16'h1 << NB[i], 0, 0, 16'h0);
      end
      xfer(1, 1, 0, 2'h1, 16'h0414, 0, 0, 16'h0);
   endtask

   task automatic t_status_enable;
      ahb(1'b0, REG_STATUS, 32'h0, rv);
      check_val("status", 32'h00000414, rv);
      ahb(1'b1, REG_STATUS, 32'hFFFFFFFF, rv);
      ahb(1'b0, REG_STATUS, 32'h0, rv);
      check_val("status", 32'h00000414, rv);
      ahb(1'b1, REG_CTRL, 32'h0, rv);
      // A disabled block ignores the end of transmission entirely
      xfer(0, 1, 0, 2'h1, 16'h0, 0, 0, 16'h0);
      ahb(1'b1, REG_CTRL, 32'h1, rv);
      ahb(1'b0, REG_CTRL, 32'h0, rv);
      check_val("ctrl", 32'h1, {31'h0, rv[CTRL_EN_BIT]});
      xfer(1, 1, 0, 2'h0, 16'h0, 0, 0, 16'h0);
   endtask

   initial begin
      errors = 0;
      n_tests = 0;
      n_exec = 0;
      n_rdreq = 0;
      RST = 1'b1;
      HSEL = 1'b0;
      HADDR = 32'h0;
      HTRANS = 2'h0;
      HWRITE = 1'b0;
      HSIZE = 3'h2;
      HWDATA = 32'h0;
      EOT_STROBE = 1'b0;
      EOT_TURN = 1'b0;
      REQ_IS_READ = 1'b0;
      REQ_VC = 2'h0;
      err_drive = 16'h0;
      RD_VALID = 1'b0;
      RD_LONG = 1'b0;
      RD_CMDSET = 1'b0;
      RD_LEN = 16'h0;
      RD_BYTE_VALID = 1'b0;
      RD_BYTE = 8'h00;
      app_wait = 4'h0;
      app_idx = 8'h00;
      slow = 1'b0;
      repeat (20) @(posedge CORE_CLK);
      RST <= 1'b0;
      @(posedge CORE_CLK);
      t_regs_reset();
      t_ack();
      t_no_turn();
      t_reads();
      t_read_err();
      t_abort();
      t_report();
      t_status_enable();
      conclude();
   end

   // Watchdog well beyond the several hundred cycles the run needs
   initial begin
      repeat (30000) @(posedge CORE_CLK);
      errors++;
      conclude();
   end
endmodule
`default_nettype wire
